// ---- tmr_ctrl.sv ----
// Timer 0/1 mode and run control, overflow flags and external interrupt flags
//
// The AXI4-Lite register port and the address map were chosen for this implementation.
`timescale 1ns/10ps
`default_nettype none
module tmr_ctrl (
   input wire logic i_sys_clk,
   input wire logic i_rst_b,
   input wire logic [tmr_pkg::ADDR_W-1:0] i_awaddr,
   input wire logic [2:0] i_awprot,
   input wire logic i_awvalid,
   output logic o_awready,
   input wire logic [31:0] i_wdata,
   input wire logic [3:0] i_wstrb,
   input wire logic i_wvalid,
   output logic o_wready,
   output logic [1:0] o_bresp,
   output logic o_bvalid,
   input wire logic i_bready,
   input wire logic [tmr_pkg::ADDR_W-1:0] i_araddr,
   input wire logic [2:0] i_arprot,
   input wire logic i_arvalid,
   output logic o_arready,
   output logic [31:0] o_rdata,
   output logic [1:0] o_rresp,
   output logic o_rvalid,
   input wire logic i_rready,
   input wire logic i_ext_irq0_pin,
   input wire logic i_ext_irq1_pin,
   input wire logic i_t0_count_pin,
   input wire logic i_t1_overflow,
   output logic o_t1_run,
   output logic [3:0] o_t1_mode,
   output logic [3:0] o_irq_req,
   output logic o_irq
);
   import tmr_pkg::*;

   ////////////////////////////////////////////////////////////////////////////////
   // State
   logic [7:0] msel_r, msel_nxt; // Mode select
   logic [7:0] flg_r, flg_nxt; // Run bits and flags
   logic [7:0] lo0_r, lo0_nxt; // Timer 0 low byte
   logic [7:0] hi0_r, hi0_nxt; // Timer 0 high byte
   logic [3:0] sts_r, sts_nxt; // Sticky event status
   logic [3:0] msk_r, msk_nxt; // Interrupt mask
   logic irq_r, irq_nxt;
   logic t1run_r, t1run_nxt;
   logic bvalid_r, bvalid_nxt;
   logic [1:0] bresp_r, bresp_nxt;
   logic rvalid_r, rvalid_nxt;
   logic [1:0] rresp_r, rresp_nxt;
   logic [31:0] rdata_r, rdata_nxt;
   // Synchronised pins: [0] ext 0, [1] ext 1, [2] count pin
   logic [2:0] pin_lvl, pin_fall;
   // Decoded strobes
   logic wr_go, wr_en, whit;
   logic wr_flg, wr_msel, wr_tl, wr_th, wr_sts, wr_msk, wr_ack;
   logic rd_go;
   // Counting terms
   tmr_mode_e t0_mode;
   logic t0_en, t0_step, th_step, t0_ovf, th_ovf;
   logic [3:0] ev; // Flag rising events, status layout

   ////////////////////////////////////////////////////////////////////////////////
   // Pin synchronisers
   tmr_pin_sync #(.N(3)) tmr_pin_sync_i (
      .i_sys_clk(i_sys_clk),
      .i_rst_b(i_rst_b),
      .i_pin({i_t0_count_pin, i_ext_irq1_pin, i_ext_irq0_pin}),
      .o_level(pin_lvl),
      .o_fall(pin_fall)
   );

   ////////////////////////////////////////////////////////////////////////////////
   // Bus slave: write address and data taken together, one write pending
   assign wr_go = i_awvalid & i_wvalid & ~bvalid_r;
   assign o_awready = wr_go;
   assign o_wready = wr_go;
   assign wr_en = wr_go & i_wstrb[0]; // Only byte lane 0 carries data
   assign rd_go = i_arvalid & ~rvalid_r;
   assign o_arready = ~rvalid_r;

   // Write address decode
   always_comb begin
      wr_flg = 1'b0;
      wr_msel = 1'b0;
      wr_tl = 1'b0;
      wr_th = 1'b0;
      wr_sts = 1'b0;
      wr_msk = 1'b0;
      wr_ack = 1'b0;
      whit = 1'b1;
      if (i_awaddr == A_RUNFLG) begin
         wr_flg = wr_en;
      end else if (i_awaddr == A_MODSEL) begin
         wr_msel = wr_en;
      end else if (i_awaddr == A_LOW0) begin
         wr_tl = wr_en;
      end else if (i_awaddr == A_HIGH0) begin
         wr_th = wr_en;
      end else if (i_awaddr == A_STS) begin
         wr_sts = wr_en;
      end else if (i_awaddr == A_MSK) begin
         wr_msk = wr_en;
      end else if (i_awaddr == A_ACK) begin
         wr_ack = wr_en;
      end else begin
         whit = 1'b0;
      end
   end

   // Responses: one cycle after acceptance, held until taken
   always_comb begin
      bvalid_nxt = bvalid_r & ~i_bready;
      bresp_nxt = bresp_r;
      rvalid_nxt = rvalid_r & ~i_rready;
      rresp_nxt = rresp_r;
      rdata_nxt = rdata_r;
      if (wr_go) begin
         bvalid_nxt = 1'b1;
         bresp_nxt = whit ? RESP_OKAY : RESP_SLVERR;
      end
      if (rd_go) begin
         rvalid_nxt = 1'b1;
         rresp_nxt = RESP_OKAY;
         rdata_nxt = 32'h0000_0000;
         if (i_araddr == A_RUNFLG) begin
            rdata_nxt[7:0] = flg_r;
         end else if (i_araddr == A_MODSEL) begin
            rdata_nxt[7:0] = msel_r;
         end else if (i_araddr == A_LOW0) begin
            rdata_nxt[7:0] = lo0_r;
         end else if (i_araddr == A_HIGH0) begin
            rdata_nxt[7:0] = hi0_r;
         end else if (i_araddr == A_STS) begin
            rdata_nxt[3:0] = sts_r;
         end else if (i_araddr == A_MSK) begin
            rdata_nxt[3:0] = msk_r;
         end else if (i_araddr == A_ACK) begin
            rdata_nxt[3:0] = 4'h0; // Write-only, reads zero
         end else begin
            rresp_nxt = RESP_SLVERR;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Timer 0 counting
   assign t0_mode = tmr_mode_e'(msel_r[1:0]);
   // Run bit gated by the ext 0 pin when gating is selected
   assign t0_en = flg_r[B_RUN0] & (~msel_r[B_GATING0] | pin_lvl[0]);
   // Count pin edges or every core clock (no divide-by-12)
   assign t0_step = t0_en & (msel_r[B_CT0] ? pin_fall[2] : 1'b1);
   // Split high byte: internal clock only, Timer 1 run bit
   assign th_step = (t0_mode == TMR_MSPLIT) & flg_r[B_RUN1];

   // Count next values; a bus write to a byte wins over counting
   always_comb begin
      lo0_nxt = lo0_r;
      hi0_nxt = hi0_r;
      t0_ovf = 1'b0;
      th_ovf = 1'b0;
      case (t0_mode)
         TMR_M13: begin
            // Low five bits prescale, upper three stay as they are
            if (t0_step) begin
               lo0_nxt[4:0] = lo0_r[4:0] + 5'h01;
               if (&lo0_r[4:0]) begin
                  hi0_nxt = hi0_r + 8'h01;
                  t0_ovf = &hi0_r;
               end
            end
         end
         TMR_M16: begin
            if (t0_step) begin
               {hi0_nxt, lo0_nxt} = {hi0_r, lo0_r} + 16'h0001;
               t0_ovf = &{hi0_r, lo0_r};
            end
         end
         TMR_M8R: begin
            if (t0_step) begin
               lo0_nxt = (&lo0_r) ? hi0_r : lo0_r + 8'h01;
               t0_ovf = &lo0_r;
            end
         end
         default: begin
            if (t0_step) begin
               lo0_nxt = lo0_r + 8'h01;
               t0_ovf = &lo0_r;
            end
            if (th_step) begin
               hi0_nxt = hi0_r + 8'h01;
               th_ovf = &hi0_r;
            end
         end
      endcase
      // Run bits never touch the bytes; only these writes do
      if (wr_tl) begin
         lo0_nxt = i_wdata[7:0];
      end
      if (wr_th) begin
         hi0_nxt = i_wdata[7:0];
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Run bits and flags; hardware set wins over any clear
   always_comb begin
      msel_nxt = wr_msel ? i_wdata[7:0] : msel_r;
      flg_nxt = wr_flg ? i_wdata[7:0] : flg_r;
      // Vectoring clears timer flags
      if (wr_ack & i_wdata[S_OVF0]) begin
         flg_nxt[B_OVF0] = 1'b0;
      end
      if (wr_ack & i_wdata[S_OVF1]) begin
         flg_nxt[B_OVF1] = 1'b0;
      end
      if (t0_ovf) begin
         flg_nxt[B_OVF0] = 1'b1;
      end
      if (th_ovf | i_t1_overflow) begin
         flg_nxt[B_OVF1] = 1'b1;
      end
      // External flags: k = 0 and 1 share one layout two bits apart
      for (int k = 0; k < 2; k++) begin
         if (flg_nxt[B_XTYP0 + 2*k]) begin
            // Edge mode: falling edge sets, vectoring clears
            if (wr_ack & i_wdata[S_XFLG0 + 2*k]) begin
               flg_nxt[B_XFLG0 + 2*k] = 1'b0;
            end
            if (pin_fall[k]) begin
               flg_nxt[B_XFLG0 + 2*k] = 1'b1;
            end
         end else begin
            // Level mode: flag follows the pin, software cannot hold it
            flg_nxt[B_XFLG0 + 2*k] = ~pin_lvl[k];
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Sticky status, mask and interrupt line
   assign ev[S_XFLG0] = flg_nxt[B_XFLG0] & ~flg_r[B_XFLG0];
   assign ev[S_OVF0] = flg_nxt[B_OVF0] & ~flg_r[B_OVF0];
   assign ev[S_XFLG1] = flg_nxt[B_XFLG1] & ~flg_r[B_XFLG1];
   assign ev[S_OVF1] = flg_nxt[B_OVF1] & ~flg_r[B_OVF1];

   // Write-one-to-clear; a new event in the same cycle survives
   always_comb begin
      sts_nxt = (wr_sts ? (sts_r & ~i_wdata[3:0]) : sts_r) | ev;
      msk_nxt = wr_msk ? i_wdata[3:0] : msk_r;
      irq_nxt = |(sts_nxt & msk_nxt);
      // Timer 1 enable: run bit, its own gate, and not in mode 11
      t1run_nxt = flg_nxt[B_RUN1] & (msel_nxt[5:4] != 2'b11)
         & (~msel_nxt[B_GATE1] | pin_lvl[1]);
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Registers
   always_ff @(posedge i_sys_clk) begin
      if (!i_rst_b) begin
         msel_r <= RST_BYTE;
         flg_r <= RST_BYTE;
         lo0_r <= RST_BYTE;
         hi0_r <= RST_BYTE;
         sts_r <= RST_STS;
         msk_r <= RST_STS;
         irq_r <= 1'b0;
         t1run_r <= 1'b0;
         bvalid_r <= 1'b0;
         bresp_r <= RESP_OKAY;
         rvalid_r <= 1'b0;
         rresp_r <= RESP_OKAY;
         rdata_r <= 32'h0000_0000;
      end else begin
         msel_r <= msel_nxt;
         flg_r <= flg_nxt;
         lo0_r <= lo0_nxt;
         hi0_r <= hi0_nxt;
         sts_r <= sts_nxt;
         msk_r <= msk_nxt;
         irq_r <= irq_nxt;
         t1run_r <= t1run_nxt;
         bvalid_r <= bvalid_nxt;
         bresp_r <= bresp_nxt;
         rvalid_r <= rvalid_nxt;
         rresp_r <= rresp_nxt;
         rdata_r <= rdata_nxt;
      end
   end

   // Outputs
   assign o_bvalid = bvalid_r;
   assign o_bresp = bresp_r;
   assign o_rvalid = rvalid_r;
   assign o_rresp = rresp_r;
   assign o_rdata = rdata_r;
   assign o_irq = irq_r;
   assign o_t1_run = t1run_r;
   assign o_t1_mode = msel_r[7:4];
   assign o_irq_req = {flg_r[B_OVF1], flg_r[B_XFLG1], flg_r[B_OVF0], flg_r[B_XFLG0]};

   ////////////////////////////////////////////////////////////////////////////////
   // Assertions
   default clocking cb @(posedge i_sys_clk); endclocking
   default disable iff (!i_rst_b);
   logic nowr;
   assign nowr = ~(wr_tl | wr_th | wr_flg | wr_msel);

   property p_gate;
      msel_r[B_GATING0] && !pin_lvl[0] && t0_mode != TMR_MSPLIT && nowr
         |=> $stable({hi0_r, lo0_r});
   endproperty
   a_gate: assert property (p_gate) else $error("gated timer moved");

   property p_count_pin;
      msel_r[B_CT0] && t0_en && t0_mode == TMR_M16 && nowr
         |=> {hi0_r, lo0_r} == $past({hi0_r, lo0_r}) + {15'h0000, $past(pin_fall[2])};
   endproperty
   a_count_pin: assert property (p_count_pin) else $error("count pin step wrong");

   property p_m13;
      t0_mode == TMR_M13 && t0_step && lo0_r[4:0] != 5'h1F && nowr
         |=> hi0_r == $past(hi0_r) && lo0_r[4:0] == $past(lo0_r[4:0]) + 5'h01;
   endproperty
   a_m13: assert property (p_m13) else $error("prescaler step wrong");

   property p_m16;
      t0_mode == TMR_M16 && t0_step && nowr
         |=> {hi0_r, lo0_r} == $past({hi0_r, lo0_r}) + 16'h0001;
   endproperty
   a_m16: assert property (p_m16) else $error("16-bit step wrong");

   property p_reload;
      t0_mode == TMR_M8R && t0_step && lo0_r == 8'hFF && nowr
         |=> lo0_r == $past(hi0_r) && flg_r[B_OVF0];
   endproperty
   a_reload: assert property (p_reload) else $error("reload missed");

   property p_split;
      t0_mode == TMR_MSPLIT && flg_r[B_RUN1] && hi0_r == 8'hFF && nowr
         |=> hi0_r == 8'h00 && flg_r[B_OVF1];
   endproperty
   a_split: assert property (p_split) else $error("split high byte wrong");

   property p_t1flag;
      i_t1_overflow |=> flg_r[B_OVF1] ##1 (flg_r[B_OVF1] || $past(wr_ack || wr_flg));
   endproperty
   a_t1flag: assert property (p_t1flag) else $error("timer 1 flag lost");

   property p_m13_wrap;
      t0_mode == TMR_M13 && t0_step && hi0_r == 8'hFF && lo0_r[4:0] == 5'h1F && nowr
         |=> flg_r[B_OVF0] && hi0_r == 8'h00 && lo0_r[4:0] == 5'h00;
   endproperty
   a_m13_wrap: assert property (p_m13_wrap) else $error("13-bit wrap wrong");

   property p_run_off;
      !flg_r[B_RUN0] && t0_mode != TMR_MSPLIT && !wr_tl && !wr_th
         |=> $stable({hi0_r, lo0_r});
   endproperty
   a_run_off: assert property (p_run_off) else $error("stopped timer moved");

   property p_lvl1;
      !flg_r[B_XTYP1] && !wr_flg |=> flg_r[B_XFLG1] == !$past(pin_lvl[1]);
   endproperty
   a_lvl1: assert property (p_lvl1) else $error("level flag not following");

   // Second cycle may legally see a vector ack or a software write
   property p_edge0;
      flg_r[B_XTYP0] && pin_fall[0] && !wr_flg
         |=> flg_r[B_XFLG0] ##1 (flg_r[B_XFLG0] || $past(wr_ack || wr_flg));
   endproperty
   a_edge0: assert property (p_edge0) else $error("edge flag not held");

   property p_t1_stop;
      msel_r[5:4] == 2'b11 && !wr_msel |=> !o_t1_run;
   endproperty
   a_t1_stop: assert property (p_t1_stop) else $error("timer 1 runs in mode 11");

   property p_irq;
      (|(ev & msk_r)) && !wr_msk |=> o_irq;
   endproperty
   a_irq: assert property (p_irq) else $error("interrupt not raised");

   c_reload: cover property (t0_mode == TMR_M8R && t0_step && lo0_r == 8'hFF);
   c_edge0: cover property (flg_r[B_XTYP0] && pin_fall[0]);
   c_split_ovf: cover property (th_ovf);
   c_irq: cover property (!o_irq ##1 o_irq);
endmodule : tmr_ctrl
`default_nettype wire

// ---- tmr_pkg.sv ----
// Shared constants and types for the timer 0/1 control and external interrupt block
package tmr_pkg;
   // Register indices; byte address is four times the index
   localparam logic [7:0] IDX_RUNFLG = 8'h88;
   localparam logic [7:0] IDX_MODSEL = 8'h89;
   localparam logic [7:0] IDX_LOW0 = 8'h8A;
   localparam logic [7:0] IDX_HIGH0 = 8'h8C;
   localparam logic [7:0] IDX_STS = 8'h90;
   localparam logic [7:0] IDX_MSK = 8'h91;
   localparam logic [7:0] IDX_ACK = 8'h92;
   localparam int ADDR_W = 12;
   localparam logic [11:0] A_RUNFLG = {2'b00, IDX_RUNFLG, 2'b00};
   localparam logic [11:0] A_MODSEL = {2'b00, IDX_MODSEL, 2'b00};
   localparam logic [11:0] A_LOW0 = {2'b00, IDX_LOW0, 2'b00};
   localparam logic [11:0] A_HIGH0 = {2'b00, IDX_HIGH0, 2'b00};
   localparam logic [11:0] A_STS = {2'b00, IDX_STS, 2'b00};
   localparam logic [11:0] A_MSK = {2'b00, IDX_MSK, 2'b00};
   localparam logic [11:0] A_ACK = {2'b00, IDX_ACK, 2'b00};
   // Mode select register fields
   localparam int B_GATING0 = 3;
   localparam int B_CT0 = 2;
   localparam int B_GATE1 = 7;
   // Run and flag register fields
   localparam int B_OVF1 = 7;
   localparam int B_RUN1 = 6;
   localparam int B_OVF0 = 5;
   localparam int B_RUN0 = 4;
   localparam int B_XFLG1 = 3;
   localparam int B_XTYP1 = 2;
   localparam int B_XFLG0 = 1;
   localparam int B_XTYP0 = 0;
   // Status, mask and vector-acknowledge bit layout
   localparam int S_XFLG0 = 0;
   localparam int S_OVF0 = 1;
   localparam int S_XFLG1 = 2;
   localparam int S_OVF1 = 3;
   // Values after reset
   localparam logic [7:0] RST_BYTE = 8'h00;
   localparam logic [3:0] RST_STS = 4'h0;
   localparam logic PIN_IDLE = 1'b1;
   // Bus answers
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
   // Timer 0 operating modes
   typedef enum logic [1:0] {
      TMR_M13 = 2'b00,
      TMR_M16 = 2'b01,
      TMR_M8R = 2'b10,
      TMR_MSPLIT = 2'b11
   } tmr_mode_e;
endpackage : tmr_pkg

// ---- tmr_pin_sync.sv ----
// Three-stage pin synchroniser with agreement filter and falling-edge pulse
`timescale 1ns/10ps
`default_nettype none
module tmr_pin_sync #(
   parameter int N = 3
) (
   input wire logic i_sys_clk,
   input wire logic i_rst_b,
   input wire logic [N-1:0] i_pin,
   output logic [N-1:0] o_level,
   output logic [N-1:0] o_fall
);
   import tmr_pkg::*;

   if (N < 1) begin : g_bad_n
      $error("tmr_pin_sync: N must be at least 1");
   end

   ////////////////////////////////////////////////////////////////////////////////
   for (genvar k = 0; k < N; k++) begin : g_bit
      logic s1_r, s2_r, s3_r; // Stage one feeds stage two only
      logic lvl_r, lvl_nxt; // Accepted level
      logic fall_r, fall_nxt; // One-cycle falling pulse
      // Accept a new level only once stages two and three agree
      always_comb begin
         lvl_nxt = (s2_r == s3_r) ? s2_r : lvl_r;
         fall_nxt = lvl_r & ~lvl_nxt;
      end
      // Registers; pins idle high so reset does not fake an edge
      always_ff @(posedge i_sys_clk) begin
         if (!i_rst_b) begin
            s1_r <= PIN_IDLE;
            s2_r <= PIN_IDLE;
            s3_r <= PIN_IDLE;
            lvl_r <= PIN_IDLE;
            fall_r <= 1'b0;
         end else begin
            s1_r <= i_pin[k];
            s2_r <= s1_r;
            s3_r <= s2_r;
            lvl_r <= lvl_nxt;
            fall_r <= fall_nxt;
         end
      end
      assign o_level[k] = lvl_r;
      assign o_fall[k] = fall_r;
   end
endmodule : tmr_pin_sync
`default_nettype wire

// ---- tmr_pin_model.sv ----
// Pin-side model: interrupt pins, count pin and timer 1 overflow
`timescale 1ns/10ps
`default_nettype none
module tmr_pin_model (
   input wire logic i_sys_clk,
   output logic o_ext_irq0_pin,
   output logic o_ext_irq1_pin,
   output logic o_t0_count_pin,
   output logic o_t1_overflow
);
   import tmr_pkg::*;
   // Pins rest high, no overflow pending
   initial begin
      o_ext_irq0_pin = PIN_IDLE;
      o_ext_irq1_pin = PIN_IDLE;
      o_t0_count_pin = PIN_IDLE;
      o_t1_overflow = 1'b0;
   end
   // Level on one request pin, changed just after an edge
   task automatic irq_pin(input int n, input logic v);
      @(posedge i_sys_clk);
      if (n == 0) o_ext_irq0_pin <= v;
      else o_ext_irq1_pin <= v;
   endtask : irq_pin
   // Four cycles a level, so the three-stage sampler never misses one
   task automatic count_falls(input int k);
      repeat (k) begin
         @(posedge i_sys_clk);
         o_t0_count_pin <= 1'b0;
         repeat (4) @(posedge i_sys_clk);
         o_t0_count_pin <= 1'b1;
         repeat (3) @(posedge i_sys_clk);
      end
   endtask : count_falls
   // One-cycle overflow pulse from the outside timer 1 counter
   task automatic ovf_pulse();
      @(posedge i_sys_clk);
      o_t1_overflow <= 1'b1;
      @(posedge i_sys_clk);
      o_t1_overflow <= 1'b0;
   endtask : ovf_pulse
endmodule : tmr_pin_model
`default_nettype wire

// ---- timer01_control_and_ext_irq_test.sv ----
// Self-checking bench for the timer control and interrupt flag block
`timescale 1ns/10ps
`default_nettype none
module timer01_control_and_ext_irq_test;
   import tmr_pkg::*;
   ////////////////////////////////////////////////////////////////
   logic i_sys_clk = 1'b0; // Core clock
   logic i_rst_b = 1'b0; // Held low at start
   logic [ADDR_W-1:0] awaddr = '0;
   logic awvalid = 1'b0;
   logic [31:0] wdata = '0;
   logic wvalid = 1'b0;
   logic bready = 1'b0;
   logic [ADDR_W-1:0] araddr = '0;
   logic arvalid = 1'b0;
   logic rready = 1'b0;
   logic awready, wready, bvalid, arready, rvalid;
   logic [1:0] bresp, rresp;
   logic [31:0] rdata;
   logic p_irq0, p_irq1, p_cnt, p_ovf; // Pin model outputs
   logic t1_run, irq;
   logic [3:0] t1_mode, irq_req;
   int err_count = 0;
   int checked = 0;
   ////////////////////////////////////////////////////////////////
   initial begin
      forever #12.5 i_sys_clk = ~i_sys_clk;
   end
   tmr_ctrl tmr_ctrl_i (.i_sys_clk(i_sys_clk), .i_rst_b(i_rst_b),
      .i_awaddr(awaddr), .i_awprot(3'h0), .i_awvalid(awvalid), .o_awready(awready),
      .i_wdata(wdata), .i_wstrb(4'hF), .i_wvalid(wvalid), .o_wready(wready),
      .o_bresp(bresp), .o_bvalid(bvalid), .i_bready(bready),
      .i_araddr(araddr), .i_arprot(3'h0), .i_arvalid(arvalid), .o_arready(arready),
      .o_rdata(rdata), .o_rresp(rresp), .o_rvalid(rvalid), .i_rready(rready),
      .i_ext_irq0_pin(p_irq0), .i_ext_irq1_pin(p_irq1), .i_t0_count_pin(p_cnt),
      .i_t1_overflow(p_ovf), .o_t1_run(t1_run), .o_t1_mode(t1_mode),
      .o_irq_req(irq_req), .o_irq(irq));
   tmr_pin_model tmr_pin_model_i (.i_sys_clk(i_sys_clk), .o_ext_irq0_pin(p_irq0),
      .o_ext_irq1_pin(p_irq1), .o_t0_count_pin(p_cnt), .o_t1_overflow(p_ovf));
   ////////////////////////////////////////////////////////////////
   // Compare and count; an unknown matches only the same unknown in the expected value
   task automatic ck(input logic [31:0] g, input logic [31:0] e);
      checked++;
      if (g !== e) begin
         err_count++;
         $display("ERROR %0t got %h expected %h", $time, g, e);
      end
   endtask : ck
   task automatic cyc(input int n);
      repeat (n) @(posedge i_sys_clk);
   endtask : cyc
   // Let registered outputs land before looking at them
   task automatic settle();
      cyc(3);
      #1;
   endtask : settle
   // Write: address and data offered together, held until taken
   task automatic wr(input logic [11:0] a, input logic [7:0] d);
      @(posedge i_sys_clk);
      awaddr <= a;
      wdata <= {24'h000000, d};
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      do @(posedge i_sys_clk); while (!(awready === 1'b1 && wready === 1'b1));
      awvalid <= 1'b0;
      wvalid <= 1'b0;
      bready <= 1'b1;
      do @(posedge i_sys_clk); while (bvalid !== 1'b1);
      ck(bresp, (a > A_ACK) ? RESP_SLVERR : RESP_OKAY);
      bready <= 1'b0;
   endtask : wr
   // Read: rready held up until the answer is sampled
   task automatic rd(input logic [11:0] a, output logic [7:0] d, input logic [1:0] er);
      @(posedge i_sys_clk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      do @(posedge i_sys_clk); while (arready !== 1'b1);
      arvalid <= 1'b0;
      do @(posedge i_sys_clk); while (rvalid !== 1'b1);
      d = rdata[7:0];
      ck(rresp, er);
      ck(rdata[31:8], 24'h000000);
      rready <= 1'b0;
   endtask : rd
   task automatic rdc(input logic [11:0] a, input logic [7:0] e);
      logic [7:0] d;
      rd(a, d, RESP_OKAY);
      ck(d, e);
   endtask : rdc
   ////////////////////////////////////////////////////////////////
   // Reset values and unmapped places
   task automatic t_reset();
      logic [7:0] d;
      rdc(A_RUNFLG, RST_BYTE);
      rdc(A_MODSEL, RST_BYTE);
      rdc(A_LOW0, RST_BYTE);
      rdc(A_HIGH0, RST_BYTE);
      rdc(A_STS, 8'h00);
      rdc(A_MSK, 8'h00);
      rdc(A_ACK, 8'h00);
      rd(12'hFFC, d, RESP_SLVERR);
      ck(d, 8'h00);
      wr(12'hFFC, 8'hFF);
      ck(irq, 1'b0);
   endtask : t_reset
   // Cascade from a preload, stop holds the bytes, ack clears the flag
   task automatic t_mode16();
      logic [7:0] d;
      wr(A_HIGH0, 8'hFF);
      wr(A_LOW0, 8'hF0);
      wr(A_MODSEL, 8'h01);
      wr(A_RUNFLG, 8'h10);
      cyc(40);
      rdc(A_RUNFLG, 8'h30);
      wr(A_RUNFLG, 8'h20);
      rdc(A_HIGH0, 8'h00);
      rd(A_LOW0, d, RESP_OKAY);
      cyc(10);
      rdc(A_LOW0, d);
      wr(A_ACK, 8'h01 << S_OVF0);
      rdc(A_RUNFLG, 8'h00);
      rdc(A_STS, 8'h01 << S_OVF0);
      wr(A_STS, 8'h01 << S_OVF0);
      rdc(A_STS, 8'h00);
   endtask : t_mode16
   // Five-bit prescale: carry after four steps, upper bits untouched
   task automatic t_mode13();
      logic [7:0] d;
      wr(A_HIGH0, 8'hFF);
      wr(A_LOW0, 8'hFC);
      wr(A_MODSEL, 8'h00);
      wr(A_RUNFLG, 8'h10);
      cyc(10);
      rdc(A_RUNFLG, 8'h30);
      wr(A_RUNFLG, 8'h00);
      rdc(A_HIGH0, 8'h00);
      rd(A_LOW0, d, RESP_OKAY);
      ck(d[7:5], 3'b111);
   endtask : t_mode13
   // Low byte reloads from the high byte on overflow
   task automatic t_mode8r();
      logic [7:0] d;
      wr(A_HIGH0, 8'hC0);
      wr(A_LOW0, 8'hF8);
      wr(A_MODSEL, 8'h02);
      wr(A_RUNFLG, 8'h10);
      cyc(30);
      rdc(A_RUNFLG, 8'h30);
      wr(A_RUNFLG, 8'h00);
      rdc(A_HIGH0, 8'hC0);
      rd(A_LOW0, d, RESP_OKAY);
      ck(d >= 8'hC0, 1'b1);
   endtask : t_mode8r
   // Gate: low request pin holds the timer, high lets it run
   task automatic t_gate();
      logic [7:0] d;
      tmr_pin_model_i.irq_pin(0, 1'b0);
      wr(A_MODSEL, 8'h09);
      wr(A_LOW0, 8'h00);
      wr(A_HIGH0, 8'h00);
      wr(A_RUNFLG, 8'h10);
      cyc(20);
      wr(A_RUNFLG, 8'h00);
      rdc(A_LOW0, 8'h00);
      tmr_pin_model_i.irq_pin(0, 1'b1);
      cyc(6);
      wr(A_RUNFLG, 8'h10);
      cyc(20);
      wr(A_RUNFLG, 8'h00);
      rd(A_LOW0, d, RESP_OKAY);
      ck(d > 8'h10, 1'b1);
   endtask : t_gate
   // Event source: exactly one step per falling edge
   task automatic t_count();
      wr(A_MODSEL, 8'h05);
      wr(A_LOW0, 8'h00);
      wr(A_HIGH0, 8'h00);
      wr(A_RUNFLG, 8'h10);
      tmr_pin_model_i.count_falls(3);
      cyc(8);
      wr(A_RUNFLG, 8'h00);
      rdc(A_LOW0, 8'h03);
      rdc(A_HIGH0, 8'h00);
   endtask : t_count
   // Split: high byte follows timer 1 run, low byte timer 0 run
   task automatic t_split();
      logic [7:0] d;
      logic [7:0] e;
      wr(A_MODSEL, 8'h03);
      wr(A_LOW0, 8'h00);
      wr(A_HIGH0, 8'h00);
      wr(A_RUNFLG, 8'h40);
      cyc(20);
      wr(A_RUNFLG, 8'h00);
      rdc(A_LOW0, 8'h00);
      rd(A_HIGH0, d, RESP_OKAY);
      ck(d > 8'h10, 1'b1);
      wr(A_RUNFLG, 8'h10);
      cyc(20);
      wr(A_RUNFLG, 8'h00);
      rdc(A_HIGH0, d);
      rd(A_LOW0, e, RESP_OKAY);
      ck(e > 8'h10, 1'b1);
   endtask : t_split
   // Timer 1 enable, stopped mode and its overflow flag
   task automatic t_timer1();
      wr(A_MODSEL, 8'h00);
      wr(A_RUNFLG, 8'h40);
      settle();
      ck(t1_run, 1'b1);
      wr(A_MODSEL, 8'hB0);
      settle();
      ck(t1_mode, 4'hB);
      ck(t1_run, 1'b0);
      wr(A_MODSEL, 8'h00);
      wr(A_RUNFLG, 8'h00);
      settle();
      ck(t1_run, 1'b0);
      tmr_pin_model_i.ovf_pulse();
      settle();
      rdc(A_RUNFLG, 8'h80);
      ck(irq_req, 4'h8);
      wr(A_ACK, 8'h01 << S_OVF1);
      rdc(A_RUNFLG, 8'h00);
   endtask : t_timer1
   // Request pin n: edge and level modes, mask, ack, status clear
   task automatic t_ext(input int n);
      logic [7:0] it;
      logic [7:0] ie;
      logic [7:0] sb;
      it = 8'h01 << ((n == 0) ? B_XTYP0 : B_XTYP1);
      ie = 8'h01 << ((n == 0) ? B_XFLG0 : B_XFLG1);
      sb = 8'h01 << ((n == 0) ? S_XFLG0 : S_XFLG1);
      wr(A_STS, 8'h0F);
      wr(A_MSK, sb);
      wr(A_RUNFLG, it);
      tmr_pin_model_i.irq_pin(n, 1'b0);
      cyc(4);
      tmr_pin_model_i.irq_pin(n, 1'b1);
      cyc(8);
      rdc(A_RUNFLG, it | ie);
      ck(irq, 1'b1);
      wr(A_ACK, sb);
      rdc(A_RUNFLG, it);
      wr(A_STS, sb);
      settle();
      ck(irq, 1'b0);
      wr(A_MSK, 8'h00);
      wr(A_RUNFLG, 8'h00);
      tmr_pin_model_i.irq_pin(n, 1'b0);
      cyc(8);
      wr(A_ACK, sb);
      rdc(A_RUNFLG, ie);
      ck(irq_req, {4'h0, sb});
      ck(irq, 1'b0);
      tmr_pin_model_i.irq_pin(n, 1'b1);
      cyc(8);
      rdc(A_RUNFLG, 8'h00);
   endtask : t_ext
   ////////////////////////////////////////////////////////////////
   task automatic test_done();
      $display("Checks %0d, errors %0d", checked, err_count);
      if (err_count == 0 && checked > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask : test_done
   // Main sequence after five cycles of reset
   initial begin
      repeat (5) @(posedge i_sys_clk);
      i_rst_b <= 1'b1;
      t_reset();
      t_mode16();
      t_mode13();
      t_mode8r();
      t_gate();
      t_count();
      t_split();
      t_timer1();
      t_ext(0);
      t_ext(1);
      test_done();
   end
   // Whole run needs under a thousand cycles; far beyond means a hang
   initial begin
      #(25 * 20000);
      err_count++;
      $display("ERROR %0t watchdog expired", $time);
      test_done();
   end
endmodule : timer01_control_and_ext_irq_test
`default_nettype wire
